// ==== bench/gioc_host_model.sv ====
// Behavioural host on the serial side: serial clock and access path level.
`timescale 1ns/1ps
`default_nettype none
module gioc_host_model (
  input wire logic pclk,
  input wire logic sck_run,
  input wire logic sck_fast,
  input wire logic miim_mode,
  output logic serial_clock_pin,
  output logic mgmt_miim_active
);
  initial serial_clock_pin = 1'b0;
  initial mgmt_miim_active = 1'b0;
  // Serial clock runs only inside a transfer and rests low between them.
  // Periods of 32 ns and 80 ns sit either side of the edge-choice limit.
  always begin
    #(sck_fast ? 16 : 40);
    serial_clock_pin = sck_run ? ~serial_clock_pin : 1'b0;
  end
  // The path level is a same-clock signal, so it moves just after an edge.
  always @(posedge pclk) mgmt_miim_active <= miim_mode;
endmodule
`default_nettype wire

// ==== bench/gioc_regs_properties.sv ====
// Concurrent checks on the ports of the global I/O control register bank.
`timescale 1ns/1ps
`default_nettype none
module gioc_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic mgmt_miim_active,
  input wire logic ib_frame_valid,
  input wire logic miim_preamble_optional_r,
  input wire logic sync_clock_output,
  input wire logic sync_clock_output_oe,
  input wire logic in_band_access_reset,
  input wire logic ib_accept_r,
  input wire logic ib_discard_r,
  input wire logic ib_respond_r,
  input wire logic [2:0] ib_port_r
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle, and a completed write of the in-band reset bit.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rst_write;
    psel && penable && pready && pwrite && paddr == 12'h410 && pwdata[29];
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_preamble_path_only: assert property (!mgmt_miim_active |=> !miim_preamble_optional_r)
    else $error("preamble option outside management link");
  a_sync_off_quiet: assert property (!sync_clock_output_oe [*2] |-> !sync_clock_output)
    else $error("sync clock moves while disabled");
  a_rst_self_clear: assert property (in_band_access_reset |=> !in_band_access_reset)
    else $error("in-band reset does not clear");
  a_rst_on_write: assert property (s_rst_write |=> ##[0:1] in_band_access_reset)
    else $error("in-band reset not started");
  a_accept_xor_discard: assert property (!(ib_accept_r && ib_discard_r))
    else $error("frame both accepted and dropped");
  a_respond_needs_accept: assert property (ib_respond_r |-> ib_accept_r)
    else $error("response for a dropped frame");
  a_frame_verdict_time: assert property (ib_accept_r || ib_discard_r |-> $past(ib_frame_valid, 2))
    else $error("frame verdict at wrong time");
  a_port_by_write: assert property (!$stable(ib_port_r) |-> $past(pwrite) && $past(penable))
    else $error("port field changed without write");
endmodule
bind gioc_regs gioc_regs_properties u_gioc_regs_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .mgmt_miim_active, .ib_frame_valid,
  .miim_preamble_optional_r, .sync_clock_output, .sync_clock_output_oe, .in_band_access_reset,
  .ib_accept_r, .ib_discard_r, .ib_respond_r, .ib_port_r);
`default_nettype wire

// ==== bench/gioc_regs_tb.sv ====
// Self-checking testbench for the global I/O control register bank.
`timescale 1ns/1ps
`default_nettype none
module gioc_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic receive_valid_strap_pin = 1'b1;
  logic [4:0] recovered_clock_ready_in = 5'h00;
  logic ib_frame_valid = 1'b0;
  logic [15:0] ib_frame_ethertype = 16'h0;
  logic [2:0] ib_frame_port = 3'h0;
  logic [47:0] ib_frame_dest_mac = 48'h0;
  logic [15:0] ib_frame_len = 16'h0;
  logic [47:0] switch_mac = 48'h02a0_0000_0a01;
  logic sck_run = 1'b0, sck_fast = 1'b0, miim_mode = 1'b0, rst_seen = 1'b0;
  wire serial_clock_pin, mgmt_miim_active, pready, pslverr, miim_preamble_optional_r;
  wire serial_launch_rising_r, sync_clock_output, sync_clock_output_oe, in_band_access_enable;
  wire in_band_access_reset, ib_accept_r, ib_discard_r, ib_respond_r;
  wire [31:0] prdata;
  wire [2:0] sync_clock_source, ib_port_r;
  wire [1:0] ib_resp_queue_r;
  wire [15:0] ib_ethertype_r;
  integer n_errors = 0;
  integer num_checks = 0;

  gioc_regs u_gioc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mgmt_miim_active, .serial_clock_pin, .receive_valid_strap_pin,
    .recovered_clock_ready_in, .ib_frame_valid, .ib_frame_ethertype, .ib_frame_port,
    .ib_frame_dest_mac, .ib_frame_len, .switch_mac, .miim_preamble_optional_r,
    .serial_launch_rising_r, .sync_clock_output, .sync_clock_output_oe, .sync_clock_source,
    .in_band_access_enable, .in_band_access_reset, .ib_accept_r, .ib_discard_r, .ib_respond_r,
    .ib_resp_queue_r, .ib_port_r, .ib_ethertype_r);
  gioc_host_model u_gioc_host_model (.pclk, .sck_run, .sck_fast, .miim_mode,
    .serial_clock_pin, .mgmt_miim_active);

  // 250 MHz clock.
  always #2 pclk = ~pclk;
  // The reset pulse lasts one cycle, so a sticky flag catches it.
  always @(posedge pclk) if (in_band_access_reset === 1'b1) rst_seen <= 1'b1;

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the wait for ready is bounded so a hang ends the run.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      print_verdict;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(12'h400, r);
    chk(r, 32'h42, "serial control reset");
    rd(12'h40c, r);
    chk(r & 32'h7f, 32'h02, "clock control reset");
    rd(12'h410, r);
    chk(r, 32'h804640fe, "in-band control reset");
    apb(1'b1, 12'h404, 32'hffffffff, r, e);
    chk(32'(e), 32'h1, "unmapped write error");
    apb(1'b0, 12'h404, 32'h0, r, e);
    chk(r, 32'h0, "unmapped read data");
    $display("test reset done");
  endtask
  task automatic t_edge;
    sck_fast <= 1'b1;
    sck_run <= 1'b1;
    repeat (150) @(posedge pclk);
    sck_run <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(serial_launch_rising_r), 32'h1, "fast clock edge");
    sck_fast <= 1'b0;
    sck_run <= 1'b1;
    repeat (300) @(posedge pclk);
    sck_run <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(serial_launch_rising_r), 32'h0, "slow clock edge");
    wr(12'h400, 32'h41);
    repeat (4) @(posedge pclk);
    chk(32'(serial_launch_rising_r), 32'h1, "manual rising");
    wr(12'h400, 32'h40);
    repeat (4) @(posedge pclk);
    chk(32'(serial_launch_rising_r), 32'h0, "manual falling");
    wr(12'h400, 32'h43);
    repeat (4) @(posedge pclk);
    chk(32'(serial_launch_rising_r), 32'h0, "manual bit ignored");
    $display("test edge done");
  endtask
  task automatic t_preamble;
    miim_mode <= 1'b1;
    wr(12'h400, 32'h46);
    repeat (3) @(posedge pclk);
    chk(32'(miim_preamble_optional_r), 32'h1, "preamble optional");
    miim_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(miim_preamble_optional_r), 32'h0, "preamble on serial path");
    miim_mode <= 1'b1;
    wr(12'h400, 32'h42);
    repeat (3) @(posedge pclk);
    chk(32'(miim_preamble_optional_r), 32'h0, "preamble required");
    $display("test preamble done");
  endtask
  // Measures the half period of the sync clock in pclk cycles.
  task automatic t_gap(input logic [31:0] v, input int half);
    int n;
    logic last;
    wr(12'h40c, v);
    repeat (12) @(posedge pclk);
    last = sync_clock_output;
    for (n = 0; n < 20 && sync_clock_output === last; n++) @(posedge pclk);
    last = sync_clock_output;
    for (n = 1; n < 20; n++) begin
      @(posedge pclk);
      if (sync_clock_output !== last) break;
    end
    chk(32'(n), 32'(half), "sync half period");
  endtask
  task automatic t_sync;
    t_gap(32'h03, 1);
    t_gap(32'h02, 5);
    wr(12'h40c, 32'h00);
    repeat (4) @(posedge pclk);
    chk(32'({sync_clock_output_oe, sync_clock_output}), 32'h0, "sync pin off");
    wr(12'h40c, 32'h02);
    $display("test sync done");
  endtask
  task automatic t_source;
    logic [31:0] r;
    logic [5:0] rdy_tbl;
    int c;
    // Crystal counts ready; ports 1 to 5 follow the pattern 10110 below.
    rdy_tbl = 6'b101101;
    recovered_clock_ready_in <= 5'b10110;
    // Codes 6 and 7 are never written.
    for (c = 0; c < 6; c++) begin
      wr(12'h40c, 32'(c * 4 + 2));
      repeat (6) @(posedge pclk);
      rd(12'h40c, r);
      chk(32'(r[7]), 32'(rdy_tbl[c]), "recovered ready");
      chk(32'(sync_clock_source), 32'(c), "clock source");
    end
    $display("test source done");
  endtask
  // Sends one frame and gathers accept, discard and respond over four cycles.
  task automatic frame(input logic [15:0] ty, input logic [2:0] pt, input logic [47:0] mac,
      input logic [15:0] len, input logic [2:0] exp);
    logic [2:0] got;
    got = 3'h0;
    @(posedge pclk);
    ib_frame_valid <= 1'b1;
    ib_frame_ethertype <= ty;
    ib_frame_port <= pt;
    ib_frame_dest_mac <= mac;
    ib_frame_len <= len;
    @(posedge pclk);
    ib_frame_valid <= 1'b0;
    repeat (4) begin
      @(posedge pclk);
      got = got | {ib_accept_r, ib_discard_r, ib_respond_r};
    end
    chk(32'(got), 32'(exp), "frame outcome");
  endtask
  task automatic t_iba;
    logic [31:0] r;
    wr(12'h410, 32'hc0801234);
    // The write lands at the edge on which wr returns, so look one edge later.
    @(posedge pclk);
    chk(32'({in_band_access_enable, ib_resp_queue_r, ib_port_r, ib_ethertype_r}),
      32'h301234, "in-band fields");
    frame(16'h1234, 3'h0, switch_mac, 16'd64, 3'b101);
    frame(16'h1234, 3'h0, switch_mac ^ 48'h1, 16'd64, 3'b010);
    frame(16'h1234, 3'h0, switch_mac, 16'd321, 3'b010);
    frame(16'h1234, 3'h0, switch_mac, 16'd320, 3'b101);
    frame(16'h40fe, 3'h0, switch_mac, 16'd64, 3'b000);
    frame(16'h1234, 3'h3, switch_mac, 16'd64, 3'b000);
    rd(12'h420, r);
    chk(r & 32'h7, 32'h7, "frame status");
    wr(12'h420, 32'h7);
    rd(12'h420, r);
    chk(r & 32'h7, 32'h0, "status cleared");
    wr(12'h410, 32'h80801234);
    frame(16'h1234, 3'h0, switch_mac ^ 48'h1, 16'd64, 3'b101);
    wr(12'h410, 32'ha0801234);
    repeat (2) @(posedge pclk);
    chk(32'(rst_seen), 32'h1, "in-band reset pulse");
    rd(12'h410, r);
    chk(r, 32'h80801234, "reset bit cleared");
    wr(12'h410, 32'h00801234);
    frame(16'h1234, 3'h0, switch_mac, 16'd64, 3'b000);
    $display("test in-band done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    t_reset;
    t_edge;
    t_preamble;
    t_sync;
    t_source;
    t_iba;
    print_verdict;
  end
endmodule
`default_nettype wire

// ==== rtl/gioc_consts.vh ====
// Constants for the global I/O control register bank: indices, fields, resets and timing.
`ifndef GIOC_CONSTS_VH
`define GIOC_CONSTS_VH

// Register indices; the APB byte address is four times the index.
`define GIOC_IDX_SIO 10'h100
`define GIOC_IDX_OCLK 10'h103
`define GIOC_IDX_IBA 10'h104
`define GIOC_IDX_STAT 10'h108

// Register select codes returned by the address decode function.
`define GIOC_SEL_NONE 3'h0
`define GIOC_SEL_SIO 3'h1
`define GIOC_SEL_OCLK 3'h2
`define GIOC_SEL_IBA 3'h3
`define GIOC_SEL_STAT 3'h4

// Serial I/O control fields and reset value.
`define GIOC_SIO_PRE_SUPP 2
`define GIOC_SIO_AUTO_EDGE 1
`define GIOC_SIO_MAN_EDGE 0
`define GIOC_SIO_RESET 8'h42

// Output clock control fields and reset values.
`define GIOC_OCLK_RDY 7
`define GIOC_OCLK_SRC_HI 4
`define GIOC_OCLK_SRC_LO 2
`define GIOC_OCLK_EN 1
`define GIOC_OCLK_FREQ 0
`define GIOC_OCLK_SRC_RESET 3'h0
`define GIOC_OCLK_SRC_XTAL 3'h0
`define GIOC_OCLK_SRC_PORT5 3'h5
`define GIOC_OCLK_EN_RESET 1'h1
`define GIOC_OCLK_FREQ_RESET 1'h0

// In-band management control fields and reset values.
`define GIOC_IBA_EN 31
`define GIOC_IBA_MATCH 30
`define GIOC_IBA_RST 29
`define GIOC_IBA_QUE_HI 23
`define GIOC_IBA_QUE_LO 22
`define GIOC_IBA_PORT_HI 18
`define GIOC_IBA_PORT_LO 16
`define GIOC_IBA_TYPE_HI 15
`define GIOC_IBA_TYPE_LO 0
`define GIOC_IBA_QUE_RESET 2'h1
`define GIOC_IBA_PORT_RESET 3'h6
`define GIOC_IBA_TYPE_RESET 16'h40fe
`define GIOC_IBA_MAX_BYTES 16'h0140

// Status fields; each event flag is write-one-to-clear.
`define GIOC_STAT_OVERSIZE 0
`define GIOC_STAT_MISMATCH 1
`define GIOC_STAT_GOOD 2
`define GIOC_STAT_LAUNCH_RISE 3
`define GIOC_STAT_FAST_SCK 4

// Timing: pclk rate, serial clock speed limit and sync clock rates.
`define GIOC_PCLK_MHZ 250
`define GIOC_PCLK_NS 4
`define GIOC_FAST_SCK_NS 40
`define GIOC_FAST_SCK_CYC (`GIOC_FAST_SCK_NS / `GIOC_PCLK_NS)
`define GIOC_SYNC_SLOW_MHZ 25
`define GIOC_SYNC_FAST_MHZ 125
`define GIOC_SYNC_HALF_SLOW (`GIOC_PCLK_MHZ / (2 * `GIOC_SYNC_SLOW_MHZ))
`define GIOC_SYNC_HALF_FAST (`GIOC_PCLK_MHZ / (2 * `GIOC_SYNC_FAST_MHZ))
`define GIOC_STRAP_WAIT 2'h2

`endif

// ==== rtl/gioc_regs.v ====
// Global I/O control register bank with APB access, serial edge choice and in-band checks.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gioc_consts.vh"

// How it works
// - A clear preamble-suppression bit makes the management link demand a preamble; set, it may be absent.
// - The preamble-suppression setting reaches only the MDIO/MDC link, never SPI or I2C access.
// - With automatic edge choice on, data out launches on the rising edge at 25 MHz or more, else falling.
// - With automatic edge choice off the manual edge bit decides, and while it is on that bit is ignored.
// - The manual edge bit picks the falling edge when 0, its reset value, and the rising edge when 1.
// - A read-only status bit shows whether the selected recovered clock is ready.
// - A three-bit field picks the sync clock source: 000 crystal, 001 to 101 ports 1 to 5, others reserved.
// - The sync clock pin drives only while enabled, and a frequency bit picks 25 MHz or 125 MHz.
// - The in-band enable bit takes its value after reset from the receive-valid strap pin.
// - With address matching on, in-band frames whose destination differs from the switch address are dropped.
// - Writing 1 to the in-band reset bit restarts the in-band state machine and the bit clears itself.
// - Each in-band response goes to the transmit priority queue held in a two-bit field, reset 01.
// - A three-bit field picks the in-band port: 000 to 011 ports 1 to 4, 110 port 5, the rest reserved.
// - In-band frames are recognised by a sixteen-bit EtherType field whose reset value is 0x40fe.
// - An in-band frame longer than 320 bytes is oversized: an error is flagged and no response is sent.
module gioc_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire mgmt_miim_active,
  input wire serial_clock_pin,
  input wire receive_valid_strap_pin,
  input wire [4:0] recovered_clock_ready_in,
  input wire ib_frame_valid,
  input wire [15:0] ib_frame_ethertype,
  input wire [2:0] ib_frame_port,
  input wire [47:0] ib_frame_dest_mac,
  input wire [15:0] ib_frame_len,
  input wire [47:0] switch_mac,
  output reg miim_preamble_optional_r,
  output reg serial_launch_rising_r,
  output reg sync_clock_output,
  output reg sync_clock_output_oe,
  output reg [2:0] sync_clock_source,
  output reg in_band_access_enable,
  output reg in_band_access_reset,
  output reg ib_accept_r,
  output reg ib_discard_r,
  output reg ib_respond_r,
  output reg [1:0] ib_resp_queue_r,
  output reg [2:0] ib_port_r,
  output reg [15:0] ib_ethertype_r
);

  // In-band checking machine states.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CHECK = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [7:0] sio_r;
  reg [2:0] oclk_src_r;
  reg oclk_en_r;
  reg oclk_freq_r;
  reg iba_match_r;
  reg rec_ready_r;
  reg stat_oversize_r;
  reg stat_mismatch_r;
  reg stat_good_r;
  reg fast_sck_r;
  reg sck_d_r;
  reg [7:0] sck_cnt_r;
  reg [1:0] strap_cnt_r;
  reg strap_done_r;
  reg [2:0] div_cnt_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] fr_type_r;
  reg [2:0] fr_port_r;
  reg [47:0] fr_mac_r;
  reg [15:0] fr_len_r;
  reg [31:0] rdata_nxt;
  reg rec_ready_nxt;
  wire sck_s;
  wire strap_s;
  wire [4:0] rec_ready_s;
  wire [2:0] sel;
  wire wr_en;
  wire sck_rise;
  wire [2:0] div_half;
  wire is_mgmt;
  wire mac_bad;
  wire too_long;

  // Map a word address onto a register; anything else is unmapped.
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00) begin
        reg_sel = `GIOC_SEL_NONE;
      end else begin
        case (addr[11:2])
          `GIOC_IDX_SIO: reg_sel = `GIOC_SEL_SIO;
          `GIOC_IDX_OCLK: reg_sel = `GIOC_SEL_OCLK;
          `GIOC_IDX_IBA: reg_sel = `GIOC_SEL_IBA;
          `GIOC_IDX_STAT: reg_sel = `GIOC_SEL_STAT;
          default: reg_sel = `GIOC_SEL_NONE;
        endcase
      end
    end
  endfunction

  // Pins from outside the clock domain pass two flops before use.
  gioc_sync #(.WIDTH(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_clock_pin, receive_valid_strap_pin, recovered_clock_ready_in}),
    .sync_out({sck_s, strap_s, rec_ready_s})
  );

  assign sel = reg_sel(paddr);
  assign wr_en = psel & penable & pready & pwrite;

  // APB slave: the answer is prepared in setup, so every access phase lasts one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (reg_sel(paddr) == `GIOC_SEL_NONE);
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // Read data; reserved bits and unmapped words read as zero.
  always @* begin
    rdata_nxt = 32'h00000000;
    case (sel)
      `GIOC_SEL_SIO: rdata_nxt[7:0] = sio_r;
      `GIOC_SEL_OCLK: begin
        rdata_nxt[`GIOC_OCLK_RDY] = rec_ready_r;
        rdata_nxt[`GIOC_OCLK_SRC_HI:`GIOC_OCLK_SRC_LO] = oclk_src_r;
        rdata_nxt[`GIOC_OCLK_EN] = oclk_en_r;
        rdata_nxt[`GIOC_OCLK_FREQ] = oclk_freq_r;
      end
      `GIOC_SEL_IBA: begin
        rdata_nxt[`GIOC_IBA_EN] = in_band_access_enable;
        rdata_nxt[`GIOC_IBA_MATCH] = iba_match_r;
        rdata_nxt[`GIOC_IBA_RST] = in_band_access_reset;
        rdata_nxt[`GIOC_IBA_QUE_HI:`GIOC_IBA_QUE_LO] = ib_resp_queue_r;
        rdata_nxt[`GIOC_IBA_PORT_HI:`GIOC_IBA_PORT_LO] = ib_port_r;
        rdata_nxt[`GIOC_IBA_TYPE_HI:`GIOC_IBA_TYPE_LO] = ib_ethertype_r;
      end
      `GIOC_SEL_STAT: begin
        rdata_nxt[`GIOC_STAT_OVERSIZE] = stat_oversize_r;
        rdata_nxt[`GIOC_STAT_MISMATCH] = stat_mismatch_r;
        rdata_nxt[`GIOC_STAT_GOOD] = stat_good_r;
        rdata_nxt[`GIOC_STAT_LAUNCH_RISE] = serial_launch_rising_r;
        rdata_nxt[`GIOC_STAT_FAST_SCK] = fast_sck_r;
      end
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Writable configuration; reserved codes are stored as written and left to software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_r <= `GIOC_SIO_RESET;
      oclk_src_r <= `GIOC_OCLK_SRC_RESET;
      oclk_en_r <= `GIOC_OCLK_EN_RESET;
      oclk_freq_r <= `GIOC_OCLK_FREQ_RESET;
      iba_match_r <= 1'b0;
      ib_resp_queue_r <= `GIOC_IBA_QUE_RESET;
      ib_port_r <= `GIOC_IBA_PORT_RESET;
      ib_ethertype_r <= `GIOC_IBA_TYPE_RESET;
      in_band_access_reset <= 1'b0;
    end else begin
      in_band_access_reset <= 1'b0;
      if (wr_en && sel == `GIOC_SEL_SIO) begin
        sio_r <= pwdata[7:0];
      end
      if (wr_en && sel == `GIOC_SEL_OCLK) begin
        oclk_src_r <= pwdata[`GIOC_OCLK_SRC_HI:`GIOC_OCLK_SRC_LO];
        oclk_en_r <= pwdata[`GIOC_OCLK_EN];
        oclk_freq_r <= pwdata[`GIOC_OCLK_FREQ];
      end
      if (wr_en && sel == `GIOC_SEL_IBA) begin
        iba_match_r <= pwdata[`GIOC_IBA_MATCH];
        in_band_access_reset <= pwdata[`GIOC_IBA_RST];
        ib_resp_queue_r <= pwdata[`GIOC_IBA_QUE_HI:`GIOC_IBA_QUE_LO];
        ib_port_r <= pwdata[`GIOC_IBA_PORT_HI:`GIOC_IBA_PORT_LO];
        ib_ethertype_r <= pwdata[`GIOC_IBA_TYPE_HI:`GIOC_IBA_TYPE_LO];
      end
    end
  end

  // The enable bit loads from the strap once the synchroniser holds a settled pin level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      in_band_access_enable <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `GIOC_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        in_band_access_enable <= strap_s;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end else if (wr_en && sel == `GIOC_SEL_IBA) begin
      in_band_access_enable <= pwdata[`GIOC_IBA_EN];
    end
  end

  // The preamble relief applies only while the management link is the active access path.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miim_preamble_optional_r <= 1'b0;
    end else begin
      miim_preamble_optional_r <= sio_r[`GIOC_SIO_PRE_SUPP] & mgmt_miim_active;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;

  // Serial clock period is measured in pclk cycles between rising edges. Near 25 MHz the
  // sampling jitter of one cycle makes the decision approximate, as the limit itself is.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_r <= 1'b0;
      sck_cnt_r <= 8'h00;
      fast_sck_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      if (sck_rise) begin
        sck_cnt_r <= 8'h00;
        fast_sck_r <= ({1'b0, sck_cnt_r} + 9'h001) <= `GIOC_FAST_SCK_CYC;
      end else if (sck_cnt_r != 8'hff) begin
        sck_cnt_r <= sck_cnt_r + 8'h01;
      end
    end
  end

  // Launch edge choice: automatic by speed, otherwise the manual bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_launch_rising_r <= 1'b0;
    end else if (sio_r[`GIOC_SIO_AUTO_EDGE]) begin
      serial_launch_rising_r <= fast_sck_r;
    end else begin
      serial_launch_rising_r <= sio_r[`GIOC_SIO_MAN_EDGE];
    end
  end

  // Ready of the selected source; the crystal is taken as always ready.
  always @* begin
    if (oclk_src_r == `GIOC_OCLK_SRC_XTAL) begin
      rec_ready_nxt = 1'b1;
    end else if (oclk_src_r <= `GIOC_OCLK_SRC_PORT5) begin
      rec_ready_nxt = rec_ready_s[oclk_src_r - 3'h1];
    end else begin
      rec_ready_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_ready_r <= 1'b0;
    end else begin
      rec_ready_r <= rec_ready_nxt;
    end
  end

  // Half periods of the sync clock in pclk cycles, cut on purpose to the divider width.
  localparam [31:0] HALF_FAST_W = `GIOC_SYNC_HALF_FAST;
  localparam [31:0] HALF_SLOW_W = `GIOC_SYNC_HALF_SLOW;

  assign div_half = oclk_freq_r ? HALF_FAST_W[2:0] : HALF_SLOW_W[2:0];

  // Sync clock divider from pclk; the selected source goes out to the clock mux.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 3'h0;
      sync_clock_output <= 1'b0;
      sync_clock_output_oe <= 1'b0;
      sync_clock_source <= `GIOC_OCLK_SRC_RESET;
    end else begin
      sync_clock_output_oe <= oclk_en_r;
      sync_clock_source <= oclk_src_r;
      if (!oclk_en_r) begin
        div_cnt_r <= 3'h0;
        sync_clock_output <= 1'b0;
      end else if (div_cnt_r >= div_half - 3'h1) begin
        div_cnt_r <= 3'h0;
        sync_clock_output <= ~sync_clock_output;
      end else begin
        div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end

  assign is_mgmt = (fr_type_r == ib_ethertype_r) && (fr_port_r == ib_port_r);
  assign mac_bad = iba_match_r && (fr_mac_r != switch_mac);
  assign too_long = fr_len_r > `GIOC_IBA_MAX_BYTES;

  // In-band frame checking machine; a frame offered while busy is not taken.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ib_frame_valid && in_band_access_enable) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      fr_type_r <= 16'h0000;
      fr_port_r <= 3'h0;
      fr_mac_r <= 48'h000000000000;
      fr_len_r <= 16'h0000;
      ib_accept_r <= 1'b0;
      ib_discard_r <= 1'b0;
      ib_respond_r <= 1'b0;
    end else if (in_band_access_reset) begin
      state_r <= ST_IDLE;
      ib_accept_r <= 1'b0;
      ib_discard_r <= 1'b0;
      ib_respond_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ib_accept_r <= 1'b0;
      ib_discard_r <= 1'b0;
      ib_respond_r <= 1'b0;
      if (state_r == ST_IDLE && ib_frame_valid) begin
        fr_type_r <= ib_frame_ethertype;
        fr_port_r <= ib_frame_port;
        fr_mac_r <= ib_frame_dest_mac;
        fr_len_r <= ib_frame_len;
      end
      if (state_r == ST_CHECK && is_mgmt) begin
        ib_accept_r <= ~mac_bad & ~too_long;
        ib_discard_r <= mac_bad | too_long;
        ib_respond_r <= ~mac_bad & ~too_long;
      end
    end
  end

  // Sticky event flags: an event in the clearing cycle wins over the clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_oversize_r <= 1'b0;
      stat_mismatch_r <= 1'b0;
      stat_good_r <= 1'b0;
    end else begin
      if (wr_en && sel == `GIOC_SEL_STAT) begin
        stat_oversize_r <= stat_oversize_r & ~pwdata[`GIOC_STAT_OVERSIZE];
        stat_mismatch_r <= stat_mismatch_r & ~pwdata[`GIOC_STAT_MISMATCH];
        stat_good_r <= stat_good_r & ~pwdata[`GIOC_STAT_GOOD];
      end
      if (state_r == ST_CHECK && is_mgmt && !in_band_access_reset) begin
        if (!mac_bad && too_long) begin
          stat_oversize_r <= 1'b1;
        end
        if (mac_bad) begin
          stat_mismatch_r <= 1'b1;
        end
        if (!mac_bad && !too_long) begin
          stat_good_r <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/gioc_sync.v ====
// Two-flop synchroniser bank for pins arriving from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module gioc_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // The first stage feeds only the second stage, so metastability settles there.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire
